/* src/ptb_timebase.sv */
// Purpose: Periodic timebase interrupt generator with Wishbone registers
// Assumes: crystal_clock and mode inputs are synchronous to mclk
// Notes: crystal_clock may run at up to mclk/2; a high level of one mclk cycle is still seen as an edge
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps

module ptb_timebase (
  input wire logic mclk,
  input wire logic rst,
  input wire logic crystal_clock,
  input wire ptb_pkg::ptb_mode_t mode,
  input wire ptb_pkg::ptb_wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic irq
);

  ptb_pkg::ptb_top_st_t st_r;
  ptb_pkg::ptb_top_st_t st_nxt;
  logic active;
  logic xtal_edge;
  logic tick;
  logic reg_open;
  logic wr_lane;
  logic [ptb_pkg::DIV_W-1:0] div_count;

  // Oscillator presence: it only stops in stop mode without its config bit
  assign active = ~mode.stop_mode | mode.osc_run_in_stop;

  // Rising crystal edge detection; input is already synchronous
  assign xtal_edge = crystal_clock & ~st_r.xtal_q & active;

  // Registers are closed to the processor in both low-power modes
  assign reg_open = ~mode.wait_mode & ~mode.stop_mode;

  // Control lives in byte lane 0 only
  assign wr_lane = wb_req.we & wb_req.sel[0];

  // Divider chain, cleared whenever the block is off
  ptb_divider u_div (
    .mclk(mclk),
    .rst(rst),
    .clear(~st_r.ctrl.run),
    .advance(xtal_edge & st_r.ctrl.run),
    .rate_sel(st_r.ctrl.rate),
    .count(div_count),
    .tick(tick)
  );

  // Next-state logic: bus access first, hardware sets last so set wins
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.xtal_q = crystal_clock;

    unique case (st_r.bus)
      ptb_pkg::BUS_IDLE: begin
        if (wb_req.cyc && wb_req.stb) begin
          st_nxt.bus = ptb_pkg::BUS_ACK;
          st_nxt.ack = 1'b1;
          st_nxt.rdat = 32'h0000_0000;
          if (reg_open) begin
            case (wb_req.adr)
              ptb_pkg::OFS_CTRL: begin
                // Acknowledge bit always reads zero
                st_nxt.rdat[7:0] = {st_r.ctrl.flag, st_r.ctrl.rate, 1'b0,
                                    st_r.ctrl.irq_en, st_r.ctrl.run, 1'b0};
                if (wr_lane) begin
                  // Flag bit ignores writes; the acknowledge bit here or a status write-one clears it
                  st_nxt.ctrl.rate = wb_req.dat[ptb_pkg::CTRL_RATE_LO +: 3];
                  st_nxt.ctrl.irq_en = wb_req.dat[ptb_pkg::CTRL_IRQEN];
                  st_nxt.ctrl.run = wb_req.dat[ptb_pkg::CTRL_RUN];
                  if (wb_req.dat[ptb_pkg::CTRL_ACK]) begin
                    st_nxt.ctrl.flag = 1'b0;
                  end
                end
              end
              ptb_pkg::OFS_STAT: begin
                st_nxt.rdat[ptb_pkg::STAT_ROLL] = st_r.ctrl.flag;
                st_nxt.rdat[ptb_pkg::STAT_OVR] = st_r.ovr;
                if (wr_lane) begin
                  // Write one to clear, shared with the acknowledge bit
                  if (wb_req.dat[ptb_pkg::STAT_ROLL]) begin
                    st_nxt.ctrl.flag = 1'b0;
                  end
                  if (wb_req.dat[ptb_pkg::STAT_OVR]) begin
                    st_nxt.ovr = 1'b0;
                  end
                end
              end
              ptb_pkg::OFS_MASK: begin
                st_nxt.rdat[1:0] = st_r.mask;
                if (wr_lane) begin
                  st_nxt.mask = wb_req.dat[1:0];
                end
              end
              ptb_pkg::OFS_COUNT: begin
                st_nxt.rdat[ptb_pkg::DIV_W-1:0] = div_count;
              end
              default: begin
                // Unmapped: answered, reads zero, writes dropped
                st_nxt.rdat = 32'h0000_0000;
              end
            endcase
          end
        end
      end
      ptb_pkg::BUS_ACK: begin
        // Ack lasts one cycle; a strobe still held is taken again from idle
        st_nxt.bus = ptb_pkg::BUS_IDLE;
      end
      default: begin
        st_nxt.bus = ptb_pkg::BUS_IDLE;
      end
    endcase

    // Rollover event; an event in the clear cycle is kept
    if (tick) begin
      st_nxt.ovr = st_nxt.ovr | st_r.ctrl.flag;
      st_nxt.ctrl.flag = 1'b1;
    end

    // Level interrupt: registered so the pin comes from a flop
    st_nxt.irq = (st_nxt.ctrl.flag & st_nxt.ctrl.irq_en & st_nxt.mask[ptb_pkg::STAT_ROLL])
               | (st_nxt.ovr & st_nxt.ctrl.irq_en & st_nxt.mask[ptb_pkg::STAT_OVR]);
  end

  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r.bus <= ptb_pkg::BUS_IDLE;
      st_r.ctrl.flag <= 1'b0;
      st_r.ctrl.rate <= ptb_pkg::RATE_RST;
      st_r.ctrl.irq_en <= 1'b0;
      st_r.ctrl.run <= 1'b0;
      st_r.ovr <= 1'b0;
      st_r.mask <= ptb_pkg::MASK_RST;
      st_r.xtal_q <= 1'b0;
      st_r.ack <= 1'b0;
      st_r.rdat <= 32'h0000_0000;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign irq = st_r.irq;

endmodule : ptb_timebase

/* src/ptb_pkg.sv */
// Purpose: Shared constants and types of the periodic timebase block
// Assumes: 32-bit classic Wishbone register access, registers of up to 15 bits in low lanes
// Notes: Offsets are byte addresses of aligned words
package ptb_pkg;

  // Divider chain length and tap table
  localparam int unsigned DIV_W = 15;
  localparam logic [3:0] TAP_BIT [0:7] = '{4'he, 4'hc, 4'ha, 4'h6,
                                            4'h5, 4'h4, 4'h3, 4'h2};

  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;

  // Field positions of timebase_control
  localparam int unsigned CTRL_FLAG = 7;
  localparam int unsigned CTRL_RATE_LO = 4;
  localparam int unsigned CTRL_ACK = 3;
  localparam int unsigned CTRL_IRQEN = 2;
  localparam int unsigned CTRL_RUN = 1;

  // Field positions of status and mask
  localparam int unsigned STAT_ROLL = 0;
  localparam int unsigned STAT_OVR = 1;

  // Reset values
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [1:0] MASK_RST = 2'h1;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ptb_bus_t;

  // Software view of the control register
  typedef struct packed {
    logic flag;
    logic [2:0] rate;
    logic irq_en;
    logic run;
  } ptb_ctrl_t;

  // Wishbone request group from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ptb_wb_req_t;

  // Power mode inputs from the system
  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic osc_run_in_stop;
  } ptb_mode_t;

  // Divider state
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } ptb_div_st_t;

  // Top-level state
  typedef struct packed {
    ptb_bus_t bus;
    ptb_ctrl_t ctrl;
    logic ovr;
    logic [1:0] mask;
    logic xtal_q;
    logic ack;
    logic [31:0] rdat;
    logic irq;
  } ptb_top_st_t;

endpackage : ptb_pkg

/* src/ptb_divider.sv */
// Purpose: Fifteen-stage divider chain with selectable rollover tap
// Assumes: advance is a one-cycle pulse per crystal edge
// Notes: tick is combinational and is registered by the parent
`timescale 1ns/1ps
module ptb_divider (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic advance,
  input wire logic [2:0] rate_sel,
  output logic [ptb_pkg::DIV_W-1:0] count,
  output logic tick
);

  ptb_pkg::ptb_div_st_t st_r;
  ptb_pkg::ptb_div_st_t st_nxt;
  logic [ptb_pkg::DIV_W-1:0] inc;
  logic [3:0] tap;

  // Tap bit rising gives the first tick at half the period, later ones at full
  always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    tap = ptb_pkg::TAP_BIT[rate_sel];
    inc = st_r.cnt + {{(ptb_pkg::DIV_W-1){1'b0}}, 1'b1};
    if (clear) begin
      st_nxt.cnt = '0;
    end else if (advance) begin
      st_nxt.cnt = inc;
      tick = ~st_r.cnt[tap] & inc[tap];
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.cnt;

endmodule : ptb_divider

/* verif/ptb_timebase_chk.sv */
// Purpose: Port checks of the periodic timebase
// Assumes: one mclk domain, rst synchronous active high
// Notes: bound to every ptb_timebase instance
`timescale 1ns/1ps
module ptb_timebase_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic crystal_clock,
  input wire ptb_pkg::ptb_mode_t mode,
  input wire ptb_pkg::ptb_wb_req_t wb_req,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Taken request is answered by a single ack cycle
  sequence taken_s;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence one_ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_handshake_a:
    assert property (taken_s |=> one_ack_s) else $error("ack not one cycle");
  ack_cause_a:
    assert property (wb_ack_o |-> $past(wb_req.cyc && wb_req.stb)) else $error("stray ack");
  closed_read_a:
    assert property (wb_ack_o && $past(!wb_req.we && (mode.wait_mode || mode.stop_mode))
      |-> wb_dat_o == 32'h0) else $error("closed register read not zero");
  ack_bit_a:
    assert property (wb_ack_o && $past(!wb_req.we && wb_req.adr == ptb_pkg::OFS_CTRL)
      |-> wb_dat_o[3] == 1'b0 && wb_dat_o[31:8] == 24'h0) else $error("ack bit read one");
  reset_quiet_a:
    assert property ($past(rst) |-> !irq && !wb_ack_o) else $error("busy after reset");
  irq_rise_a:
    assert property ($rose(irq) |-> wb_ack_o || $past(crystal_clock) && !$past(crystal_clock, 2))
      else $error("irq rose without cause");
  irq_fall_a:
    assert property ($fell(irq) |-> wb_ack_o || $past(rst)) else $error("irq fell without write");
  stop_halt_a:
    assert property ($rose(irq) && $past(mode.stop_mode && !mode.osc_run_in_stop) |-> wb_ack_o)
      else $error("timebase ran in stop");
endmodule : ptb_timebase_chk
bind ptb_timebase ptb_timebase_chk chk (.mclk, .rst, .crystal_clock, .mode, .wb_req,
  .wb_ack_o, .wb_dat_o, .irq);

/* verif/periodic_timebase_interrupt_test.sv */
// Purpose: Self-checking bench of the periodic timebase
// Assumes: crystal driven as level steps of one mclk cycle, one rising edge per two mclk cycles
// Notes: flag probed one edge before and at each rollover of the rate test
`timescale 1ns/1ps
module periodic_timebase_interrupt_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic xtal = 1'b0;
  ptb_pkg::ptb_mode_t mode = '0;
  ptb_pkg::ptb_wb_req_t rq = '0;
  logic ack;
  logic irq;
  logic [31:0] dat;
  logic [32:0] q[$];
  logic [31:0] seed = 32'hdbd8;
  int error_cnt = 0;
  int cmp_count = 0;
  int dv[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
  ptb_timebase dut (.mclk, .rst, .crystal_clock(xtal), .mode, .wb_req(rq), .wb_ack_o(ack),
    .wb_dat_o(dat), .irq);
  always #10 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Classic cycle; the note rides the queue until ack shows
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
    q.push_back(e);
    rq <= '{1'b1, 1'b1, w, a, 4'hf, d};
    @(posedge mclk);
    while (!ack) @(posedge mclk);
    rq <= '0;
    @(posedge mclk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, rnd(), {1'b1, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 33'h0);
  endtask : wr
  // Upper lanes random; only the low byte may matter
  task automatic wc(input logic [31:0] b);
    wr(ptb_pkg::OFS_CTRL, (rnd() << 8) | b);
  endtask : wc
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge mclk) xtal <= 1'b1;
      @(posedge mclk) xtal <= 1'b0;
    end
  endtask : edges
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Read data is judged against the oldest note
  always @(posedge mclk) begin
    if (ack) begin
      if (q[0][32]) chk("rdata", dat, q[0][31:0]);
      void'(q.pop_front());
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(ptb_pkg::OFS_CTRL, 32'h0);
    rd(ptb_pkg::OFS_MASK, 32'h1);
    rd(8'h10, 32'h0);
    // Every rate: first flag at half period; full period checked for rates 3 to 7 only
    for (int r = 7; r >= 0; r--) begin
      wc(r << 4);
      wc((r << 4) | 6);
      edges(dv[r] / 2 - 1);
      rd(ptb_pkg::OFS_CTRL, (r << 4) | 6);
      edges(1);
      rd(ptb_pkg::OFS_CTRL, (r << 4) | 8'h86);
      chk("irq", {31'h0, irq}, 32'h1);
      wc((r << 4) | 8'he);
      chk("irq", {31'h0, irq}, 32'h0);
      if (r > 2) begin
        edges(dv[r] - 1);
        rd(ptb_pkg::OFS_CTRL, (r << 4) | 6);
        edges(1);
        rd(ptb_pkg::OFS_CTRL, (r << 4) | 8'h86);
        wc((r << 4) | 8'he);
      end
      wc(32'h0);
      rd(ptb_pkg::OFS_COUNT, 32'h0);
    end
    $display("rate test done");
    wc(32'h70);
    wc(32'h76);
    mode <= 3'b100;
    wc(32'h0);
    rd(ptb_pkg::OFS_CTRL, 32'h0);
    edges(4);
    mode <= 3'b010;
    edges(4);
    mode <= 3'b011;
    edges(3);
    mode <= 3'b000;
    rd(ptb_pkg::OFS_COUNT, 32'h7);
    rd(ptb_pkg::OFS_CTRL, 32'hf6);
    $display("power mode test done");
    wr(ptb_pkg::OFS_MASK, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(ptb_pkg::OFS_MASK, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(ptb_pkg::OFS_STAT, 32'h1);
    wr(ptb_pkg::OFS_STAT, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(ptb_pkg::OFS_STAT, 32'h0);
    // Count runs 7 to 20: ticks at 12 and 20, the second one while the flag is still set
    edges(13);
    rd(ptb_pkg::OFS_STAT, 32'h3);
    wr(ptb_pkg::OFS_MASK, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ptb_pkg::OFS_STAT, 32'h3);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(ptb_pkg::OFS_STAT, 32'h0);
    $display("interrupt test done");
    print_verdict();
  end
  // Run takes about 44k cycles
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
endmodule : periodic_timebase_interrupt_test
